/* File: hdl/dac_host_map.svh */
// offsets, field positions, reset values and timing counts of the serial dac host controller
`ifndef DAC_HOST_MAP_SVH
`define DAC_HOST_MAP_SVH

// =====================================================================
// register offsets (byte addresses, one aligned word each)
`define DH_CTRL_OFS      8'h00
`define DH_TXDATA_OFS    8'h04
`define DH_STATUS_OFS    8'h08
`define DH_RXDATA_OFS    8'h0c
`define DH_WRDIV_OFS     8'h10
`define DH_RDDIV_OFS     8'h14

// =====================================================================
// field positions
`define DH_CTRL_VAR14_BIT    0
`define DH_STAT_BUSY_BIT     0
`define DH_STAT_PACE_BIT     1
`define DH_STAT_RXVALID_BIT  2
`define DH_STAT_RDPEND_BIT   3

// =====================================================================
// frame layout
`define DH_FRAME_BITS    5'd24
`define DH_MODE_SPECIAL  2'b00
`define DH_FUNC_RDSEL    6'h05
`define DH_PAD_MASK      24'hfffffc

// =====================================================================
// timing: rates in kHz, times in ns, cycle counts derived from them
`define DH_MCLK_KHZ       200000
`define DH_SCLK_WR_KHZ    50000
`define DH_SCLK_RD_KHZ    20000
`define DH_WR_HALF_CYC    ((`DH_MCLK_KHZ + 2 * `DH_SCLK_WR_KHZ - 1) / (2 * `DH_SCLK_WR_KHZ))
`define DH_RD_HALF_CYC    ((`DH_MCLK_KHZ + 2 * `DH_SCLK_RD_KHZ - 1) / (2 * `DH_SCLK_RD_KHZ))
`define DH_STAGE_NS       600
`define DH_STAGE_CYC      ((`DH_STAGE_NS * `DH_MCLK_KHZ + 999999) / 1000000)

// =====================================================================
// reset values
`define DH_CTRL_RST      1'b0
`define DH_WRDIV_RST     8'(`DH_WR_HALF_CYC)
`define DH_RDDIV_RST     8'(`DH_RD_HALF_CYC)

`endif

/* File: hdl/dac_host_pkg.sv */
// types shared by the serial dac host controller modules
package dac_host_pkg;

  // =====================================================================
  // frame sequencer states
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_SETUP,
    ST_LOW,
    ST_HIGH,
    ST_HOLD,
    ST_GAP
  } fsm_t;

  // pins driven toward the converter
  typedef struct packed {
    logic syncN;
    logic serialClk;
    logic serialIn;
  } spi_pins_t;

  // apb answer group
  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } apb_resp_t;

  // whole state of the controller
  typedef struct packed {
    fsm_t        st;
    logic [4:0]  bitCnt;
    logic [23:0] txSh;
    logic [23:0] rxSh;
    logic [23:0] rxData;
    logic        rxValid;
    logic        rdPend;
    logic        curRead;
    logic        curSelect;
    logic        curWrite;
    logic [5:0]  curAddr;
    logic        var14;
    logic [7:0]  wrDiv;
    logic [7:0]  rdDiv;
    logic [11:0] pace;
    spi_pins_t   pins;
    apb_resp_t   apb;
  } host_state_t;

  // divider state
  typedef struct packed {
    logic [7:0] cnt;
    logic       tick;
  } div_state_t;

  // synchroniser state
  typedef struct packed {
    logic ff1;
    logic ff2;
    logic ff3;
    logic level;
  } sync_state_t;

endpackage

/* File: hdl/dac_serial_host.sv */
// host controller that drives the 24-bit serial port of a 32-channel dac
//
// Our own choices: the placing of the registers and register access over APB.
module dac_serial_host (
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        srst,
  // apb slave
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // converter serial pins
  output logic             syncN,
  output logic             serialClk,
  output logic             serialIn,
  input  wire logic        serialOut
);

`include "dac_host_map.svh"

  dac_host_pkg::host_state_t s_r;
  dac_host_pkg::host_state_t s_nxt;

  logic       tick;
  logic       outSync;
  logic       startFrame;
  logic [7:0] halfSel;
  logic       apbSetup;
  logic       apbWrite;
  logic       apbRead;

  // =====================================================================
  // channel count of a write frame, used for pacing
  function automatic logic [5:0] chanCount(input logic [5:0] addr);
    logic [2:0] upper;
    logic [2:0] lower;
    upper = addr[5:3];
    lower = addr[2:0];
    chanCount = 6'h00;
    case (upper)
      3'b000: begin
        if (lower == 3'b000) begin
          chanCount = 6'h20;
        end else if (lower <= 3'b100) begin
          chanCount = 6'h08;
        end else begin
          chanCount = 6'h00;
        end
      end
      3'b001, 3'b010, 3'b011, 3'b100: chanCount = 6'h01;
      3'b110: chanCount = 6'h04;
      3'b111: chanCount = 6'h03;
      default: chanCount = 6'h00;
    endcase
  endfunction

  // =====================================================================
  // helpers
  pin_sync u_sync (
    .mclk (mclk),
    .srst (srst),
    .din  (serialOut),
    .dout (outSync)
  );

  // readback frames run on the slower divider
  assign halfSel = s_r.curRead ? s_r.rdDiv : s_r.wrDiv;

  tick_divider u_div (
    .mclk       (mclk),
    .srst       (srst),
    .restart    (startFrame),
    .halfCycles (halfSel),
    .tick       (tick)
  );

  // apb phases; request taken on the access edge with pready high
  assign apbSetup = psel && !penable;
  assign apbWrite = psel && penable && s_r.apb.pready && pwrite;
  assign apbRead  = psel && penable && s_r.apb.pready && !pwrite;
  assign startFrame = apbWrite && (paddr == `DH_TXDATA_OFS) && (s_r.st == dac_host_pkg::ST_IDLE);

  // =====================================================================
  // next state
  always_comb begin
    logic [23:0] frame;
    logic [5:0]  chans;
    frame = pwdata[23:0];
    chans = 6'h00;
    s_nxt = s_r;

    // pacing counter runs down every cycle
    if (s_r.pace != 12'h000) begin
      s_nxt.pace = 12'(s_r.pace - 12'h001);
    end

    // ---------------- apb answer ----------------
    s_nxt.apb.pready  = 1'b0;
    s_nxt.apb.pslverr = 1'b0;
    if (apbSetup) begin
      s_nxt.apb.pready = 1'b1;
      s_nxt.apb.prdata = 32'h00000000;
      case (paddr)
        `DH_CTRL_OFS:   s_nxt.apb.prdata[`DH_CTRL_VAR14_BIT] = s_r.var14;
        `DH_TXDATA_OFS: s_nxt.apb.prdata[23:0] = s_r.txSh;
        `DH_STATUS_OFS: begin
          s_nxt.apb.prdata[`DH_STAT_BUSY_BIT]    = (s_r.st != dac_host_pkg::ST_IDLE);
          s_nxt.apb.prdata[`DH_STAT_PACE_BIT]    = (s_r.pace != 12'h000);
          s_nxt.apb.prdata[`DH_STAT_RXVALID_BIT] = s_r.rxValid;
          s_nxt.apb.prdata[`DH_STAT_RDPEND_BIT]  = s_r.rdPend;
        end
        `DH_RXDATA_OFS: s_nxt.apb.prdata[23:0] = s_r.rxData;
        `DH_WRDIV_OFS:  s_nxt.apb.prdata[7:0]  = s_r.wrDiv;
        `DH_RDDIV_OFS:  s_nxt.apb.prdata[7:0]  = s_r.rdDiv;
        default:        s_nxt.apb.pslverr      = 1'b1;
      endcase
    end

    // register writes; a zero written to a divider floors at one
    if (apbWrite) begin
      case (paddr)
        `DH_CTRL_OFS:  s_nxt.var14 = pwdata[`DH_CTRL_VAR14_BIT];
        `DH_WRDIV_OFS: s_nxt.wrDiv = (pwdata[7:0] == 8'h00) ? 8'h01 : pwdata[7:0];
        `DH_RDDIV_OFS: s_nxt.rdDiv = (pwdata[7:0] == 8'h00) ? 8'h01 : pwdata[7:0];
        default: ;
      endcase
    end

    // reading the receive word consumes it
    if (apbRead && paddr == `DH_RXDATA_OFS) begin
      s_nxt.rxValid = 1'b0;
    end

    // ---------------- frame sequencer ----------------
    case (s_r.st)
      dac_host_pkg::ST_IDLE: begin
        s_nxt.pins.syncN     = 1'b1;
        s_nxt.pins.serialClk = 1'b1;
        if (startFrame) begin
          if (s_r.var14) begin
            frame = frame & `DH_PAD_MASK;
          end
          s_nxt.txSh      = 24'(frame << 1);
          s_nxt.pins.serialIn = frame[23];
          s_nxt.curAddr   = frame[21:16];
          s_nxt.curWrite  = (frame[23:22] != `DH_MODE_SPECIAL);
          s_nxt.curSelect = (frame[23:22] == `DH_MODE_SPECIAL) &&
                            (frame[21:16] == `DH_FUNC_RDSEL);
          s_nxt.curRead   = s_r.rdPend || s_nxt.curSelect;
          s_nxt.bitCnt    = 5'd0;
          s_nxt.rxSh      = 24'h000000;
          s_nxt.pins.syncN = 1'b0;
          s_nxt.st        = dac_host_pkg::ST_SETUP;
        end
      end
      dac_host_pkg::ST_SETUP: begin
        // data settles for one half period before the first fall
        if (tick) begin
          s_nxt.pins.serialClk = 1'b0;
          s_nxt.bitCnt = 5'(s_r.bitCnt + 5'd1);
          s_nxt.st     = dac_host_pkg::ST_LOW;
        end
      end
      dac_host_pkg::ST_LOW: begin
        if (tick) begin
          // sample late in the low half so the device output has settled
          s_nxt.rxSh = {s_r.rxSh[22:0], outSync};
          s_nxt.pins.serialClk = 1'b1;
          if (s_r.bitCnt == `DH_FRAME_BITS) begin
            s_nxt.st = dac_host_pkg::ST_HOLD;
          end else begin
            s_nxt.pins.serialIn = s_r.txSh[23];
            s_nxt.txSh = 24'(s_r.txSh << 1);
            s_nxt.st   = dac_host_pkg::ST_HIGH;
          end
        end
      end
      dac_host_pkg::ST_HIGH: begin
        if (tick) begin
          s_nxt.pins.serialClk = 1'b0;
          s_nxt.bitCnt = 5'(s_r.bitCnt + 5'd1);
          s_nxt.st     = dac_host_pkg::ST_LOW;
        end
      end
      dac_host_pkg::ST_HOLD: begin
        // gated clock of exactly 24 pulses: sync may rise once the earlier write has settled
        if (tick && s_r.pace == 12'h000) begin
          s_nxt.pins.syncN = 1'b1;
          if (s_r.curWrite) begin
            chans = chanCount(s_r.curAddr);
            s_nxt.pace = 12'(chans * 12'(`DH_STAGE_CYC));
          end
          if (s_r.rdPend) begin
            s_nxt.rxData  = s_r.var14 ? (s_r.rxSh & `DH_PAD_MASK) : s_r.rxSh;
            s_nxt.rxValid = 1'b1;                         // set wins over the read clear
          end
          s_nxt.rdPend = s_r.curSelect;
          s_nxt.st     = dac_host_pkg::ST_GAP;
        end
      end
      dac_host_pkg::ST_GAP: begin
        // sync stays high for one half period before another frame
        if (tick) begin
          s_nxt.curRead = 1'b0;
          s_nxt.st      = dac_host_pkg::ST_IDLE;
        end
      end
      default: begin
        s_nxt.st = dac_host_pkg::ST_IDLE;
      end
    endcase
  end

  // =====================================================================
  // state register
  always_ff @(posedge mclk) begin
    if (srst) begin
      s_r                <= '0;
      s_r.st             <= dac_host_pkg::ST_IDLE;
      s_r.var14          <= `DH_CTRL_RST;
      s_r.wrDiv          <= `DH_WRDIV_RST;
      s_r.rdDiv          <= `DH_RDDIV_RST;
      s_r.pins.syncN     <= 1'b1;
      s_r.pins.serialClk <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  // =====================================================================
  // outputs straight from the state register
  assign prdata    = s_r.apb.prdata;
  assign pready    = s_r.apb.pready;
  assign pslverr   = s_r.apb.pslverr;
  assign syncN     = s_r.pins.syncN;
  assign serialClk = s_r.pins.serialClk;
  assign serialIn  = s_r.pins.serialIn;

endmodule

/* File: hdl/pin_sync.sv */
// three-flop synchroniser with agreement filter for a pin input
module pin_sync (
  // clock and reset
  input  wire logic mclk,
  input  wire logic srst,
  // pin and result
  input  wire logic din,
  output logic      dout
);

  dac_host_pkg::sync_state_t s_r;
  dac_host_pkg::sync_state_t s_nxt;

  // =====================================================================
  // first flop feeds only the second; level moves once flops 2 and 3 agree
  always_comb begin
    s_nxt     = s_r;
    s_nxt.ff1 = din;
    s_nxt.ff2 = s_r.ff1;
    s_nxt.ff3 = s_r.ff2;
    if (s_r.ff2 == s_r.ff3) begin
      s_nxt.level = s_r.ff3;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign dout = s_r.level;

endmodule

/* File: hdl/tick_divider.sv */
// half-period enable divider for the serial clock
module tick_divider (
  // clock and reset
  input  wire logic       mclk,
  input  wire logic       srst,
  // control
  input  wire logic       restart,
  input  wire logic [7:0] halfCycles,
  // enable out
  output logic            tick
);

  dac_host_pkg::div_state_t s_r;
  dac_host_pkg::div_state_t s_nxt;

  // =====================================================================
  // count to halfCycles, then pulse for one cycle
  always_comb begin
    s_nxt      = s_r;
    s_nxt.tick = 1'b0;
    if (restart) begin
      s_nxt.cnt = 8'h00;
    end else if (8'(s_r.cnt + 8'h01) >= halfCycles) begin
      s_nxt.cnt  = 8'h00;
      s_nxt.tick = 1'b1;
    end else begin
      s_nxt.cnt = 8'(s_r.cnt + 8'h01);
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign tick = s_r.tick;

endmodule

/* File: tb/dac_host_checker.sv */
// checker for the apb answer and the serial pin timing of the dac host controller
module dac_host_checker (
  // clock and reset
  input wire logic       mclk,
  input wire logic       srst,
  // apb
  input wire logic [7:0] paddr,
  input wire logic       psel,
  input wire logic       penable,
  input wire logic       pready,
  input wire logic       pslverr,
  // serial pins
  input wire logic       syncN,
  input wire logic       serialClk,
  input wire logic       serialIn
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [4:0] fallCnt_r;
  logic       clkPrev_r;

  default clocking @(posedge mclk); endclocking
  default disable iff (srst);

  // count serial clock falls in the open frame; a 5-bit count still shows a 25th fall
  always_ff @(posedge mclk) begin
    clkPrev_r <= serialClk;
    if (srst || syncN) begin
      fallCnt_r <= 5'h0;
    end else if (clkPrev_r && !serialClk) begin
      fallCnt_r <= fallCnt_r + 5'h1;
    end
  end

  // =====================================================================
  // apb answer
  a_pready_next: assert property (psel && !penable |=> pready)
    else $error("no answer in the cycle after setup");
  a_pready_single: assert property (pready |=> !pready)
    else $error("pready held longer than one cycle");
  a_err_unmapped: assert property (psel && !penable && paddr > 8'h14 |=> pslverr && pready)
    else $error("unmapped address not refused");
  a_err_mapped: assert property (psel && !penable && paddr <= 8'h14 && paddr[1:0] == 2'h0 |=> !pslverr)
    else $error("mapped address refused");

  // =====================================================================
  // serial frame shape
  a_clk_idle: assert property (syncN |-> serialClk)
    else $error("serial clock not idle high outside a frame");
  a_sync_setup: assert property ($fell(syncN) |-> serialClk [*2])
    else $error("serial clock moved too soon after sync fell");
  a_frame_len: assert property ($rose(syncN) |-> fallCnt_r == 5'd24)
    else $error("frame closed without exactly 24 falls");
  a_no_extra: assert property (!syncN |-> fallCnt_r <= 5'd24)
    else $error("more than 24 falls in one frame");
  a_bit_stable: assert property ($fell(serialClk) |-> $stable(serialIn))
    else $error("data changed on the sampling edge");
  a_sync_gap: assert property ($rose(syncN) |-> syncN [*2])
    else $error("sync high time too short between frames");
endmodule

bind dac_serial_host dac_host_checker u_chk (
  .mclk(mclk), .srst(srst), .paddr(paddr), .psel(psel), .penable(penable), .pready(pready),
  .pslverr(pslverr), .syncN(syncN), .serialClk(serialClk), .serialIn(serialIn)
);

/* File: tb/dac_port_model.sv */
// behavioural model of the converter's serial port and its input registers
module dac_port_model (
  // pins from the host
  input  wire logic syncN,
  input  wire logic serialClk,
  input  wire logic serialIn,
  // readback pin
  output logic      serialOut
);
  timeunit 1ns;
  timeprecision 1ps;
  // banks 0..3: input a, input b, offset, gain; calculated values are not held here
  logic [15:0] mem [128];
  logic [23:0] sh, lastFrame, rdWord;
  logic [5:0]  falls;
  logic        bank, drive;
  int          paceErr, nCh;
  time         doneAt, busyNs;

  initial begin
    foreach (mem[i]) mem[i] = 16'h0;
    {sh, lastFrame, rdWord, falls, bank, drive, serialOut} = '0;
    {paceErr, nCh, doneAt, busyNs} = '0;
  end

  // channel selected by a six-bit address code
  function automatic logic hit(input logic [5:0] a, input logic [4:0] ch);
    case (a[5:3])
      3'd0: return a[2:0] == 3'd0 || (a[2:0] < 3'd5 && ch[4:3] == a[1:0] - 2'd1);
      3'd5: return 1'b0;
      3'd6: return ch[2:0] == a[2:0];
      3'd7: return ch[2:0] == a[2:0] && ch[4:3] != 2'd0;
      default: return ch[4:3] == a[4:3] - 2'd1 && ch[2:0] == a[2:0];
    endcase
  endfunction

  // a frame opens on the falling sync edge
  always @(negedge syncN) begin
    falls = 6'd0;
  end

  // bits are taken on falling clock edges while sync is low, msb first
  always @(negedge serialClk) begin
    if (!syncN) begin
      falls = falls + 6'd1;
      sh = {sh[22:0], serialIn};
    end
  end

  // readback bits move after each rising edge so the host sees them settled
  always @(posedge serialClk) begin
    if (drive && !syncN) begin
      rdWord = {rdWord[22:0], 1'b0};
      serialOut = rdWord[23];
    end
  end

  // frame close: short or long frames are dropped, pacing is policed
  always @(posedge syncN) begin
    if (drive) begin
      drive = 1'b0;
      serialOut = ~serialOut;
    end
    if (falls == 6'd24) begin
      lastFrame = sh;
      if ($time - doneAt < busyNs) paceErr++;
      nCh = 0;
      if (sh[23:22] != 2'b00) begin
        for (int c = 0; c < 32; c++) begin
          if (hit(sh[21:16], 5'(c))) begin
            mem[{(sh[23:22] == 2'b11 ? {1'b0, bank} : {1'b1, sh[22]}), 5'(c)}] = sh[15:0];
            nCh++;
          end
        end
        doneAt = $time;
        busyNs = nCh * 600;
      end else if (sh[21:16] == 6'h01) begin
        bank = sh[2];
      end else if (sh[21:16] == 6'h05) begin
        rdWord = {8'h00, mem[{sh[14:13], 5'(sh[12:7] - 6'd8)}]};
        drive = 1'b1;
        serialOut = rdWord[23];
      end
    end
  end
endmodule

/* File: tb/dac_serial_host_tb.sv */
// self-checking bench for the serial dac host controller
`include "dac_host_map.svh"
module dac_serial_host_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        mclk, srst, psel, penable, pwrite, pready, pslverr, err;
  logic        syncN, serialClk, serialIn, serialOut;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, q;
  int          n_errors = 0;
  int          check_count = 0;
  int          cyc = 0;
  time         lastFall = 0;
  time         clkPer = 0;

  dac_serial_host u_dut (
    .mclk(mclk), .srst(srst), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .syncN(syncN), .serialClk(serialClk), .serialIn(serialIn), .serialOut(serialOut)
  );
  dac_port_model u_dev (.syncN(syncN), .serialClk(serialClk), .serialIn(serialIn), .serialOut(serialOut));

  // 200 MHz clock
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  // serial clock period, measured between the last two falls
  always @(negedge serialClk) begin
    clkPer = $time - lastFall;
    lastFall = $time;
  end

  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", s, e, g);
    end
  endtask

  // one apb transfer; request held until pready is seen high
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) n_errors++;
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // start one frame, then poll status until the controller is idle
  task automatic send(input logic [23:0] f);
    int n;
    n = 0;
    apb(`DH_TXDATA_OFS, 1'b1, {8'h00, f});
    do begin
      apb(`DH_STATUS_OFS, 1'b0, 32'h0);
      n++;
    end while (q[`DH_STAT_BUSY_BIT] !== 1'b0 && n < 3000);
    if (n >= 3000) n_errors++;
  endtask

  task automatic t_regs;
    apb(`DH_WRDIV_OFS, 1'b0, 32'h0);
    chk("wrdiv", 32'h2, q);
    apb(`DH_RDDIV_OFS, 1'b0, 32'h0);
    chk("rddiv", 32'h5, q);
    apb(8'h18, 1'b1, 32'h1);
    chk("unmapped", 32'h1, {31'h0, err});
    $display("test regs done");
  endtask

  // single-channel writes in modes 01, 10 and 11, then bank b through the control word
  task automatic t_write;
    logic [1:0] m;
    for (int i = 1; i < 4; i++) begin
      m = 2'(i);
      send({m, 6'o13, 8'h5a, 6'h0, m});
      chk("frame", {8'h0, m, 6'o13, 8'h5a, 6'h0, m}, u_dev.lastFrame);
      chk("reg", {8'h5a, 6'h0, m}, u_dev.mem[{(m == 2'b11 ? 2'd0 : {1'b1, m[0]}), 5'd3}]);
      chk("write period", 32'd20, 32'(clkPer));
    end
    send(24'h010004);
    send({2'b11, 6'o20, 16'h1234});
    chk("bank b", 32'h1234, u_dev.mem[{2'd1, 5'd8}]);
    send(24'h010000);
    $display("test write done");
  endtask

  // group and broadcast codes, reserved codes, pacing of long writes
  task automatic t_group;
    send({2'b10, 6'o02, 16'hbeef});
    chk("pacing flag", 32'h1, {31'h0, q[`DH_STAT_PACE_BIT]});
    chk("group in", 32'hbeef, u_dev.mem[{2'd2, 5'd15}]);
    chk("group out", 32'h0, u_dev.mem[{2'd2, 5'd16}]);
    send({2'b01, 6'o65, 16'h0f0f});
    chk("all groups", 32'h0f0f, u_dev.mem[{2'd3, 5'd29}]);
    send({2'b01, 6'o76, 16'h7777});
    chk("groups 1-3", 32'h7777, u_dev.mem[{2'd3, 5'd14}]);
    chk("group 0 kept", 32'h0, u_dev.mem[{2'd3, 5'd6}]);
    send({2'b11, 6'o00, 16'h4242});
    send({2'b11, 6'o50, 16'hdead});
    send({2'b11, 6'o05, 16'hdead});
    chk("reserved", 32'h4242, u_dev.mem[{2'd0, 5'd31}]);
    chk("pacing", 32'h0, u_dev.paceErr);
    $display("test group done");
  endtask

  // select offset of channel 15, then fetch it in the next frame
  task automatic t_read;
    send({2'b00, 6'h05, 3'b010, 6'd23, 7'h0});
    chk("select period", 32'd50, 32'(clkPer));
    send(24'h000000);
    chk("data period", 32'd50, 32'(clkPer));
    apb(`DH_STATUS_OFS, 1'b0, 32'h0);
    chk("status rx", 32'h4, q);
    apb(`DH_RXDATA_OFS, 1'b0, 32'h0);
    chk("readback", 32'h0000beef, q);
    apb(`DH_STATUS_OFS, 1'b0, 32'h0);
    chk("status consumed", 32'h0, q);
    $display("test read done");
  endtask

  // short variant forces the two pad bits low
  task automatic t_var14;
    apb(`DH_CTRL_OFS, 1'b1, 32'h1);
    send(24'hffffff);
    chk("pad bits", 32'h00fffffc, u_dev.lastFrame);
    apb(`DH_CTRL_OFS, 1'b1, 32'h0);
    $display("test var14 done");
  endtask

  task automatic finish_test;
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // hang guard, far above the expected run length
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      n_errors++;
      finish_test();
    end
  end

  // reset, then the scenarios in order
  initial begin
    srst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h0;
    pwdata = 32'h0;
    repeat (16) @(posedge mclk);
    srst <= 1'b0;
    t_regs();
    t_write();
    t_group();
    t_read();
    t_var14();
    finish_test();
  end
endmodule
